// ---- rtl/lpps_core.sv ----
`timescale 1ns/1ps
// How it works
// - stagger bit 0 disables group stagger, 1 enables it
// - channels split into six groups of six consecutive outputs
// - each group lags the previous one by a sixth of the period
// - rate select picks slow layer (0) or fast layer (1) for stagger
// - alignment bit set: odd outputs start-aligned, even outputs end-aligned
// - alignment bit clear: whole group start-aligned, the default
// - stagger and alignment may act together
// - both off: all outputs switch on together at cycle start
// - writing zero to the restore register resets every register
// - three scale registers for green, red and blue channel groups
// - each scale sets group current in 256 steps
// - slow duty per channel from 0/256 to 255/256
// - fast pwm nested inside each slow unit, 8 or 10 bit duty
// - default 8-bit resolution, slow 256 fast periods
// - rgb mode: each channel triple shares one pwm register
// - slow layer can be disabled leaving only the fast layer
// - rate field picks slow rate in 8-bit mode only; fast layer stays well above audio
// - power-down bit clear turns off all outputs, registers kept
module lpps_core #(
   parameter int CH = 36
) (
   input wire logic clock,
   input wire logic srst,
   input wire lpps_pkg::lpps_req_t req,
   output logic [7:0] rd_data,
   output logic [CH-1:0] led_channel,
   output lpps_pkg::lpps_scale_t current_scale,
   output logic current_enable
);

   if (CH != lpps_pkg::GROUPS * lpps_pkg::GROUP_SIZE)
   begin : bad_ch
      $error("lpps_core: channel count must be six groups of six");
   end

   // =====================================================================
   // register file
   logic [7:0] ctrl_r;
   logic [7:0] phase_r;
   lpps_pkg::lpps_scale_t scale_r;
   logic [7:0] slow_duty_r [CH];
   logic [9:0] fast_duty_r [CH];
   logic [7:0] sh_slow_r [CH];
   logic [9:0] sh_fast_r [CH];
   logic [7:0] rd_data_r;
   logic [7:0] rd_nxt;
   logic [CH-1:0] led_r;
   logic [CH-1:0] on_w;

   wire restore_w = req.wr && req.addr == lpps_pkg::ADDR_RESTORE
                    && req.wdata == lpps_pkg::RESTORE_KEY;
   wire clr_w = srst || restore_w;
   wire wr_ctrl_w = req.wr && req.addr == lpps_pkg::ADDR_CTRL;
   wire wr_phase_w = req.wr && req.addr == lpps_pkg::ADDR_PHASE;
   wire wr_green_w = req.wr && req.addr == lpps_pkg::ADDR_GREEN;
   wire wr_red_w = req.wr && req.addr == lpps_pkg::ADDR_RED;
   wire wr_blue_w = req.wr && req.addr == lpps_pkg::ADDR_BLUE;

   wire pwr_w = ctrl_r[lpps_pkg::CTRL_PWR_BIT];
   wire [1:0] rate_w = ctrl_r[lpps_pkg::CTRL_RATE_LSB +: 2];
   wire hires_w = ctrl_r[lpps_pkg::CTRL_HIRES_BIT];
   wire slow_off_w = ctrl_r[lpps_pkg::CTRL_SLOW_OFF_BIT];
   wire rgb_w = ctrl_r[lpps_pkg::CTRL_RGB_BIT];
   wire stag_w = phase_r[lpps_pkg::PH_EN_BIT];
   wire stag_fast_w = phase_r[lpps_pkg::PH_RATE_BIT];

   always_ff @(posedge clock)
   begin
      if (clr_w)
      begin
         ctrl_r <= lpps_pkg::CTRL_RST;
         phase_r <= lpps_pkg::PHASE_RST;
         scale_r <= {3{lpps_pkg::SCALE_RST}};
      end
      else
      begin
         if (wr_ctrl_w)
            ctrl_r <= req.wdata;
         if (wr_phase_w)
            phase_r <= req.wdata;
         if (wr_green_w)
            scale_r.green <= req.wdata;
         if (wr_red_w)
            scale_r.red <= req.wdata;
         if (wr_blue_w)
            scale_r.blue <= req.wdata;
      end
   end

   // =====================================================================
   // shared counters
   logic [9:0] fast_cnt_r;
   logic [7:0] slow_cnt_r;
   logic [9:0] fast_step_w;

   // 8-bit mode trades fast resolution for a higher slow rate
   wire [9:0] fast_mask_w = hires_w ? lpps_pkg::FAST10_MASK : lpps_pkg::FAST8_MASK;
   assign fast_step_w = hires_w ? lpps_pkg::FAST_STEP_1
                        : rate_w == 2'h0 ? lpps_pkg::FAST_STEP_1
                        : rate_w == 2'h1 ? lpps_pkg::FAST_STEP_2
                        : lpps_pkg::FAST_STEP_4;
   // greater-than also recovers when a mode change leaves the count past the end
   wire fast_last_w = fast_cnt_r > fast_mask_w - fast_step_w;
   wire slow_last_w = fast_last_w && slow_cnt_r == lpps_pkg::SLOW_MAX;
   wire load_w = slow_off_w ? fast_last_w : slow_last_w;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         fast_cnt_r <= 10'h000;
         slow_cnt_r <= 8'h00;
      end
      else
      begin
         fast_cnt_r <= fast_last_w ? 10'h000 : fast_cnt_r + fast_step_w;
         if (fast_last_w)
            slow_cnt_r <= slow_cnt_r + 8'h01;
      end
   end

   // =====================================================================
   // per-group phase
   logic [7:0] slow_ph [lpps_pkg::GROUPS];
   logic [9:0] fast_ph [lpps_pkg::GROUPS];

   for (genvar g = 0; g < lpps_pkg::GROUPS; g++)
   begin : grp
      localparam logic [7:0] SOFF = 8'((g * 256) / lpps_pkg::GROUPS);
      localparam logic [9:0] FOFF8 = 10'((g * 256) / lpps_pkg::GROUPS);
      localparam logic [9:0] FOFF10 = 10'((g * 1024) / lpps_pkg::GROUPS);
      wire [9:0] foff_w = hires_w ? FOFF10 : FOFF8;
      assign slow_ph[g] = (stag_w && !stag_fast_w) ? slow_cnt_r - SOFF
                          : slow_cnt_r;
      assign fast_ph[g] = (stag_w && stag_fast_w) ? (fast_cnt_r - foff_w) & fast_mask_w
                          : fast_cnt_r;
   end

   // =====================================================================
   // channels
   for (genvar i = 0; i < CH; i++)
   begin : chn
      localparam int G = i / lpps_pkg::GROUP_SIZE;
      localparam int SRC = (i / 3) * 3;
      localparam logic [7:0] A_LO = 8'(int'(lpps_pkg::ADDR_FAST_BASE) + 2 * i);
      localparam logic [7:0] A_HI = 8'(int'(lpps_pkg::ADDR_FAST_BASE) + 2 * i + 1);
      localparam logic [7:0] A_SL = 8'(int'(lpps_pkg::ADDR_SLOW_BASE) + i);
      localparam bit EVEN_POS = (i % lpps_pkg::GROUP_SIZE) % 2 == 1;

      wire mirror_w = phase_r[G] && EVEN_POS;
      wire [7:0] sd_w = rgb_w ? sh_slow_r[SRC] : sh_slow_r[i];
      wire [9:0] fd_raw_w = rgb_w ? sh_fast_r[SRC] : sh_fast_r[i];
      wire [9:0] fd_w = hires_w ? fd_raw_w : {2'h0, fd_raw_w[7:0]};
      // end alignment mirrors the group phase, so stagger still applies
      wire [7:0] spos_w = mirror_w ? ~slow_ph[G] : slow_ph[G];
      wire [9:0] fpos_w = mirror_w ? fast_mask_w - fast_ph[G] : fast_ph[G];
      assign on_w[i] = pwr_w && (slow_off_w || spos_w < sd_w)
                       && fpos_w < fd_w;

      always_ff @(posedge clock)
      begin
         if (clr_w)
         begin
            slow_duty_r[i] <= lpps_pkg::SLOW_DUTY_RST;
            fast_duty_r[i] <= lpps_pkg::FAST_DUTY_RST;
         end
         else if (req.wr && req.addr == A_SL)
            slow_duty_r[i] <= req.wdata;
         else if (req.wr && req.addr == A_LO)
            fast_duty_r[i][7:0] <= req.wdata;
         else if (req.wr && req.addr == A_HI)
            fast_duty_r[i][9:8] <= req.wdata[1:0];
      end

      // shadows keep a pulse whole when software rewrites mid-cycle
      always_ff @(posedge clock)
      begin
         if (srst)
         begin
            sh_slow_r[i] <= lpps_pkg::SLOW_DUTY_RST;
            sh_fast_r[i] <= lpps_pkg::FAST_DUTY_RST;
         end
         else if (load_w)
         begin
            sh_slow_r[i] <= slow_duty_r[i];
            sh_fast_r[i] <= fast_duty_r[i];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         led_r <= '0;
      else
         led_r <= on_w;
   end

   // =====================================================================
   // read back
   wire [7:0] fidx_w = (req.addr - lpps_pkg::ADDR_FAST_BASE) >> 1;
   wire [7:0] sidx_w = req.addr - lpps_pkg::ADDR_SLOW_BASE;
   wire in_fast_w = req.addr >= lpps_pkg::ADDR_FAST_BASE
                    && req.addr < lpps_pkg::ADDR_SLOW_BASE;
   wire in_slow_w = req.addr >= lpps_pkg::ADDR_SLOW_BASE
                    && req.addr < lpps_pkg::ADDR_GREEN - 8'h01 + 8'h01
                    && sidx_w < 8'(CH);

   always_comb
   begin
      if (req.addr == lpps_pkg::ADDR_CTRL)
         rd_nxt = ctrl_r;
      else if (in_fast_w)
         rd_nxt = req.addr[0] ? fast_duty_r[fidx_w[5:0]][7:0]
                  : {6'h00, fast_duty_r[fidx_w[5:0]][9:8]};
      else if (in_slow_w)
         rd_nxt = slow_duty_r[sidx_w[5:0]];
      else if (req.addr == lpps_pkg::ADDR_GREEN)
         rd_nxt = scale_r.green;
      else if (req.addr == lpps_pkg::ADDR_RED)
         rd_nxt = scale_r.red;
      else if (req.addr == lpps_pkg::ADDR_BLUE)
         rd_nxt = scale_r.blue;
      else if (req.addr == lpps_pkg::ADDR_PHASE)
         rd_nxt = phase_r;
      else
         rd_nxt = 8'h00;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         rd_data_r <= 8'h00;
      else if (req.rd)
         rd_data_r <= rd_nxt;
   end

   assign rd_data = rd_data_r;
   assign led_channel = led_r;
   assign current_scale = scale_r;
   assign current_enable = pwr_w;

   // =====================================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   power_down_dark_a: assert property (!pwr_w |=> led_channel == '0)
      else $error("outputs lit while powered down");
   stagger_off_a: assert property (!stag_w |-> slow_ph[5] == slow_cnt_r
                                   && fast_ph[5] == fast_cnt_r)
      else $error("phase shift while stagger disabled");
   slow_lag_a: assert property (stag_w && !stag_fast_w |-> slow_ph[1] == slow_cnt_r - 8'h2A
                                && fast_ph[1] == fast_cnt_r)
      else $error("slow group lag wrong");
   fast_lag_a: assert property (stag_w && stag_fast_w && hires_w
                                |-> fast_ph[3] == ((fast_cnt_r - 10'h200) & 10'h3FF)
                                && slow_ph[3] == slow_cnt_r)
      else $error("fast group lag wrong");
   restore_defaults_a: assert property (restore_w |=> ctrl_r == 8'h00 && phase_r == 8'h00
                                        && scale_r == '0 && slow_duty_r[7] == 8'h00)
      else $error("restore write left registers set");
   shadow_hold_a: assert property (!load_w |=> $stable(sh_slow_r[0])
                                   && $stable(sh_fast_r[0]))
      else $error("duty shadow changed mid-cycle");
   rgb_shared_a: assert property (rgb_w && phase_r[0] == 1'b0
                                  |-> on_w[1] == on_w[0] && on_w[2] == on_w[0])
      else $error("rgb triple not sharing pwm");
   fast_zero_a: assert property (sh_fast_r[4] == 10'h000 && !rgb_w |-> !on_w[4])
      else $error("channel lit with zero fast duty");
   slow_layer_off_a: assert property (slow_off_w && pwr_w && !rgb_w && !stag_w
                                      && sh_fast_r[0][7:0] != 8'h00 && fast_cnt_r == 10'h000
                                      |-> on_w[0])
      else $error("slow layer not bypassed");
   end_align_a: assert property (phase_r[0] && !stag_w && !rgb_w && pwr_w && slow_off_w
                                 && sh_fast_r[1][7:0] != 8'h00 && fast_last_w
                                 |-> on_w[1])
      else $error("even output not end aligned");

   stagger_run_c: cover property (stag_w && !stag_fast_w && slow_last_w);
   align_run_c: cover property (phase_r[0] && on_w[1] && !on_w[0]);
   restore_c: cover property (restore_w ##1 pwr_w == 1'b0);

endmodule : lpps_core

// ---- shared/lpps_pkg.sv ----
package lpps_pkg;

   // =====================================================================
   // register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FAST_BASE = 8'h01;
   localparam logic [7:0] ADDR_SLOW_BASE = 8'h49;
   localparam logic [7:0] ADDR_GREEN = 8'h6E;
   localparam logic [7:0] ADDR_RED = 8'h6F;
   localparam logic [7:0] ADDR_BLUE = 8'h70;
   localparam logic [7:0] ADDR_PHASE = 8'h71;
   localparam logic [7:0] ADDR_RESTORE = 8'h7F;
   localparam logic [7:0] RESTORE_KEY = 8'h00;

   // =====================================================================
   // control and phase register fields
   localparam int CTRL_PWR_BIT = 0;
   localparam int CTRL_RATE_LSB = 1;
   localparam int CTRL_HIRES_BIT = 3;
   localparam int CTRL_SLOW_OFF_BIT = 4;
   localparam int CTRL_RGB_BIT = 5;
   localparam int PH_EN_BIT = 7;
   localparam int PH_RATE_BIT = 6;

   // =====================================================================
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PHASE_RST = 8'h00;
   localparam logic [7:0] SCALE_RST = 8'h00;
   localparam logic [7:0] SLOW_DUTY_RST = 8'h00;
   localparam logic [9:0] FAST_DUTY_RST = 10'h000;

   // =====================================================================
   // counting
   localparam int GROUPS = 6;
   localparam int GROUP_SIZE = 6;
   localparam logic [7:0] SLOW_MAX = 8'hFF;
   localparam logic [9:0] FAST8_MASK = 10'h0FF;
   localparam logic [9:0] FAST10_MASK = 10'h3FF;
   localparam logic [9:0] FAST_STEP_1 = 10'h001;
   localparam logic [9:0] FAST_STEP_2 = 10'h002;
   localparam logic [9:0] FAST_STEP_4 = 10'h004;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lpps_req_t;

   typedef struct packed {
      logic [7:0] green;
      logic [7:0] red;
      logic [7:0] blue;
   } lpps_scale_t;

endpackage : lpps_pkg

// ---- verif/led_pwm_phase_shaper_tb.sv ----
`timescale 1ns/1ps
module led_pwm_phase_shaper_tb;
   localparam int P = 256;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic clear = 1'b0;
   lpps_pkg::lpps_req_t req = '0;
   logic [7:0] rd_data;
   logic [35:0] led_channel;
   lpps_pkg::lpps_scale_t current_scale;
   logic current_enable;
   int on_cnt [36];
   int rise_at [36];
   int err_count = 0;
   int samples_checked = 0;
   int off [6] = '{0, 42, 85, 128, 170, 213};
   // fast-layer stagger keeps the run short; slow layer is the usual choice
   logic [7:0] phases [4] = '{8'h00, 8'h01, 8'hC0, 8'hC1};
   logic [7:0] duty [4] = '{8'h00, 8'h01, 8'h40, 8'hFF};
   logic [7:0] regs [6] = '{lpps_pkg::ADDR_CTRL, lpps_pkg::ADDR_GREEN, lpps_pkg::ADDR_RED,
      lpps_pkg::ADDR_BLUE, lpps_pkg::ADDR_PHASE, lpps_pkg::ADDR_RESTORE};

   always #50 clock = ~clock;

   lpps_core #(.CH(36)) i_dut (.clock(clock), .srst(srst), .req(req), .rd_data(rd_data),
      .led_channel(led_channel), .current_scale(current_scale),
      .current_enable(current_enable));
   lpps_led_model #(.CH(36)) i_leds (.clock(clock), .clear(clear),
      .led_channel(led_channel), .on_cnt(on_cnt), .rise_at(rise_at));

   // =====================================================================
   // access and checking tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      req.addr = a;
      req.wdata = d;
      req.wr = 1'b1;
      @(negedge clock);
      req.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock);
      req.addr = a;
      req.rd = 1'b1;
      @(negedge clock);
      req.rd = 1'b0;
      // read data stands, so one spare cycle costs nothing
      @(negedge clock);
      chk($sformatf("reg %0h", a), {24'h0, exp}, {24'h0, rd_data});
   endtask : rd

   task automatic fast(input int ch, input logic [7:0] d);
      wr(lpps_pkg::ADDR_FAST_BASE + 8'(2 * ch), d);
   endtask : fast

   // settle two loads, then watch four whole periods
   task automatic measure;
      repeat (2 * P) @(negedge clock);
      clear = 1'b1;
      @(negedge clock);
      clear = 1'b0;
      repeat (4 * P) @(negedge clock);
   endtask : measure

   function automatic logic [31:0] rdiff(input int a, input int b);
      return 32'((((rise_at[a] - rise_at[b]) % P) + P) % P);
   endfunction : rdiff

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   // =====================================================================
   // scenarios
   initial
   begin
      repeat (4) @(negedge clock);
      srst = 1'b0;
      chk("scale out", 32'h0, {8'h0, current_scale});
      chk("enable", 32'h0, {31'h0, current_enable});
      foreach (regs[i]) rd(regs[i], 8'h00);
      wr(lpps_pkg::ADDR_GREEN, 8'hA5);
      wr(lpps_pkg::ADDR_RED, 8'h5A);
      wr(lpps_pkg::ADDR_BLUE, 8'h3C);
      wr(8'h75, 8'hFF);
      rd(lpps_pkg::ADDR_GREEN, 8'hA5);
      rd(lpps_pkg::ADDR_RED, 8'h5A);
      rd(lpps_pkg::ADDR_BLUE, 8'h3C);
      rd(8'h75, 8'h00);
      chk("scale out", 32'h00A55A3C, {8'h0, current_scale});
      for (int i = 0; i < 4; i++) fast(i, duty[i]);
      fast(4, 8'h40);
      fast(5, 8'h40);
      for (int g = 1; g < 6; g++) fast(6 * g, 8'h80);
      wr(lpps_pkg::ADDR_CTRL, 8'h10);
      measure;
      chk("dark ch4", 32'h0, 32'(on_cnt[4]));
      chk("dark all", 32'h0, {31'h0, |led_channel});
      chk("enable", 32'h0, {31'h0, current_enable});
      rd(lpps_pkg::ADDR_FAST_BASE + 8'h08, 8'h40);
      wr(lpps_pkg::ADDR_CTRL, 8'h11);
      chk("enable", 32'h1, {31'h0, current_enable});
      foreach (phases[p])
      begin
         wr(lpps_pkg::ADDR_PHASE, phases[p]);
         measure;
         for (int i = 0; i < 4; i++)
            chk($sformatf("lit ch%0d", i), {22'h0, duty[i], 2'b00}, 32'(on_cnt[i]));
         chk("align ch5", phases[p][0] ? 32'd192 : 32'd0, rdiff(5, 4));
         for (int g = 1; g < 6; g++)
            chk($sformatf("lag g%0d", g), phases[p][7] ? 32'(off[g]) : 32'd0, rdiff(6 * g, 4));
      end
      wr(lpps_pkg::ADDR_PHASE, 8'h00);
      wr(lpps_pkg::ADDR_CTRL, 8'h31);
      measure;
      chk("rgb ch1", 32'h0, 32'(on_cnt[1]));
      chk("rgb ch2", 32'h0, 32'(on_cnt[2]));
      chk("rgb ch4", {22'h0, duty[3], 2'b00}, 32'(on_cnt[4]));
      wr(lpps_pkg::ADDR_SLOW_BASE + 8'h05, 8'h77);
      rd(lpps_pkg::ADDR_SLOW_BASE + 8'h05, 8'h77);
      wr(lpps_pkg::ADDR_RESTORE, 8'h55);
      rd(lpps_pkg::ADDR_GREEN, 8'hA5);
      wr(lpps_pkg::ADDR_RESTORE, lpps_pkg::RESTORE_KEY);
      foreach (regs[i]) rd(regs[i], 8'h00);
      rd(lpps_pkg::ADDR_FAST_BASE, 8'h00);
      chk("scale out", 32'h0, {8'h0, current_scale});
      chk("enable", 32'h0, {31'h0, current_enable});
      end_of_test;
   end

   initial
   begin
      repeat (60000) @(negedge clock);
      err_count++;
      $display("[FAIL] run length expected below 60000 cycles seen 60000");
      end_of_test;
   end
endmodule : led_pwm_phase_shaper_tb

// ---- verif/lpps_led_model.sv ----
`timescale 1ns/1ps
// =====================================================================
// led strings on the sinks: lit time and first turn-on per channel
module lpps_led_model #(
   parameter int CH = 36
) (
   input wire logic clock,
   input wire logic clear,
   input wire logic [CH-1:0] led_channel,
   output int on_cnt [CH],
   output int rise_at [CH]
);
   int cyc;
   logic [CH-1:0] prev;
   always @(posedge clock)
   begin
      if (clear)
      begin
         cyc <= 0;
         prev <= led_channel;
         for (int i = 0; i < CH; i++)
         begin
            on_cnt[i] <= 0;
            rise_at[i] <= -1;
         end
      end
      else
      begin
         cyc <= cyc + 1;
         prev <= led_channel;
         for (int i = 0; i < CH; i++)
         begin
            // unknown counts as dark, so a stray x shows as a short gap
            if (led_channel[i] === 1'b1)
               on_cnt[i] <= on_cnt[i] + 1;
            if (led_channel[i] === 1'b1 && prev[i] !== 1'b1 && rise_at[i] < 0)
               rise_at[i] <= cyc;
         end
      end
   end
endmodule : lpps_led_model
